// >>> hw/dbt_pkg.sv
// Constants for the dual byte timer with PWM outputs
package dbt_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_TIMER_CONTROL     = 16'hFE18;
  localparam logic [15:0] IDX_PRESCALER_CONTROL = 16'hFE19;
  localparam logic [15:0] IDX_LOW_BYTE_COUNT    = 16'hFE1A;
  localparam logic [15:0] IDX_HIGH_BYTE_COUNT   = 16'hFE1B;
  localparam logic [15:0] IDX_LOW_MATCH_DATA    = 16'hFE1C;
  localparam logic [15:0] IDX_HIGH_MATCH_DATA   = 16'hFE1D;

  // Reset values
  localparam logic [7:0]  RST_TIMER_CONTROL     = 8'h00;
  localparam logic [7:0]  RST_PRESCALER_CONTROL = 8'h00;
  localparam logic [7:0]  RST_COUNT             = 8'h00;
  localparam logic [7:0]  RST_MATCH_DATA        = 8'h00;

  // timer_control fields
  localparam int BIT_HIGH_BYTE_RUN       = 7;
  localparam int BIT_LOW_BYTE_RUN        = 6;
  localparam int BIT_LENGTH_SELECT       = 5;
  localparam int BIT_OUTPUT_MODE_SELECT  = 4;
  localparam int BIT_HIGH_MATCH_FLAG     = 3;
  localparam int BIT_HIGH_IRQ_ENABLE     = 2;
  localparam int BIT_LOW_MATCH_FLAG      = 1;
  localparam int BIT_LOW_IRQ_ENABLE      = 0;

  // prescaler_control fields
  localparam int BIT_HIGH_PRESCALE_EN    = 7;
  localparam int POS_HIGH_PRESCALE_SEL   = 4;
  localparam int BIT_LOW_PRESCALE_EN     = 3;
  localparam int POS_LOW_PRESCALE_SEL    = 0;

  // Match data value that forces a running output low; count value at which a counter overflows
  localparam logic [7:0]  MATCH_DATA_FULL       = 8'hFF;
  localparam logic [7:0]  COUNT_TOP             = 8'hFF;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ         = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ            = 2'h3;
  localparam logic        HRESP_OKAY            = 1'b0;
endpackage

// >>> hw/dbt_timer.sv
// Dual byte timer with toggle and PWM outputs, AHB-Lite register slave
//
// Overview of operation
// - High run bit 0 holds high counter at 0, buffer follows high match data.
// - Low run bit 0 holds low counter at 0, buffer follows low match data.
// - Length select 0: two 8-bit timers; 1: high advances once per low period.
// - Each byte raises its own match when count equals its buffer, in all modes.
// - Modes 0,2 toggle both; mode 1 PWM both; mode 3 high toggle, low PWM.
// - High match flag set when running high counter reaches 0, cleared by software.
// - Interrupt request while high enable and high match flag are both 1.
// - Low match flag set when running low counter reaches 0, cleared by software.
// - Interrupt request while low enable and low match flag are both 1, shared.
// - Prescaler writes while running take effect only at match buffer reload.
// - High prescale count is 1 when disabled, else two to the select plus one.
// - Low prescale count is 1 when disabled, else two to the select plus one.
// - Low counter is read-only, counts up once per low prescaler pulse.
// - High counter is read-only, counts up once per high prescaler pulse.
// - Low match data feeds an 8-bit buffer compared with the low count.
// - High match data feeds an 8-bit buffer compared with the high count.
// - Running low buffer reloads from low match data only when low count reaches 0.
// - Running high buffer reloads from high match data only when high count reaches 0.
// - Low counter clears on match in modes 0 and 2, and when stopped.
// - High counter clears on match in modes 0, 2 and 3, and when stopped.
// - PWM output low on overflow, high on match; toggle output inverts on match.
// - Output high while stopped; low while running with match data FFH.
`timescale 1ns/1ps
`default_nettype none
module dbt_timer
  import dbt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  output logic             irq_request_o,
  output logic             low_waveform_out_o,
  output logic             high_waveform_out_o
);

  // Last prescaler count value for the given enable and select
  function automatic logic [7:0] pre_last(input logic en, input logic [2:0] sel);
    logic [8:0] cnt;
    cnt = 9'h002 << sel;
    pre_last = en ? 8'(cnt - 9'h001) : 8'h00;
  endfunction

  // Register index of a word address, all-ones when not aligned or out of range
  function automatic logic [15:0] word_index(input logic [31:0] addr);
    word_index = (addr[1:0] == 2'h0 && addr[31:18] == 14'h0000) ? addr[17:2] : 16'hFFFF;
  endfunction

  logic [7:0]  timer_control;
  logic [7:0]  prescaler_control;
  logic [7:0]  low_byte_match_data;
  logic [7:0]  high_byte_match_data;
  logic [7:0]  low_byte_count;
  logic [7:0]  high_byte_count;
  logic [7:0]  low_buf;
  logic [7:0]  high_buf;
  logic [3:0]  low_pre_act;
  logic [3:0]  high_pre_act;
  logic [7:0]  low_pcnt;
  logic [7:0]  high_pcnt;
  logic        half_tick;
  logic        wr_pend;
  logic [15:0] wr_idx;

  logic        high_byte_run;
  logic        low_byte_run;
  logic        length_select;
  logic        output_mode_select;
  logic        low_base;
  logic        high_base;
  logic        low_tick;
  logic        high_tick;
  logic        low_match;
  logic        high_match;
  logic        low_ovf;
  logic        high_ovf;
  logic        low_clr_on_match;
  logic        high_clr_on_match;
  logic [7:0]  next_low_count;
  logic [7:0]  next_high_count;
  logic        low_zero;
  logic        high_zero;
  logic        low_pwm;
  logic        high_pwm;
  logic        addr_phase;
  logic [15:0] addr_idx;
  logic [7:0]  rd_byte;

  assign high_byte_run      = timer_control[BIT_HIGH_BYTE_RUN];
  assign low_byte_run       = timer_control[BIT_LOW_BYTE_RUN];
  assign length_select      = timer_control[BIT_LENGTH_SELECT];
  assign output_mode_select = timer_control[BIT_OUTPUT_MODE_SELECT];

  // Output styles per mode
  assign low_pwm  = output_mode_select;
  assign high_pwm = output_mode_select && !length_select;

  // Prescaler input clocks: 2 cycles in toggle modes, 1 cycle in PWM modes, low match or overflow for cascaded high in modes 2 and 3
  assign low_base = output_mode_select ? 1'b1 : half_tick;
  always_comb begin
    case ({length_select, output_mode_select})
      2'b00:   high_base = half_tick;
      2'b01:   high_base = 1'b1;
      2'b10:   high_base = low_match;
      default: high_base = low_ovf;
    endcase
  end

  assign low_tick  = low_byte_run && low_base &&
                     (low_pcnt == pre_last(low_pre_act[3], low_pre_act[2:0]));
  assign high_tick = high_byte_run && high_base &&
                     (high_pcnt == pre_last(high_pre_act[3], high_pre_act[2:0]));

  assign low_match  = low_tick && (low_byte_count == low_buf);
  assign high_match = high_tick && (high_byte_count == high_buf);
  assign low_ovf    = low_tick && (low_byte_count == COUNT_TOP);
  assign high_ovf   = high_tick && (high_byte_count == COUNT_TOP);

  assign low_clr_on_match  = !output_mode_select;
  assign high_clr_on_match = !output_mode_select || length_select;

  assign next_low_count  = (low_match && low_clr_on_match) ? 8'h00
                         : 8'(low_byte_count + 8'h01);
  assign next_high_count = (high_match && high_clr_on_match) ? 8'h00
                         : 8'(high_byte_count + 8'h01);
  assign low_zero  = low_tick && (next_low_count == 8'h00);
  assign high_zero = high_tick && (next_high_count == 8'h00);

  // Two-cycle base tick
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      half_tick <= 1'b0;
    end else begin
      half_tick <= !half_tick;
    end
  end

  // Prescalers, cleared while stopped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_pcnt  <= 8'h00;
      high_pcnt <= 8'h00;
    end else begin
      if (!low_byte_run || low_tick) begin
        low_pcnt <= 8'h00;
      end else if (low_base) begin
        low_pcnt <= 8'(low_pcnt + 8'h01);
      end
      if (!high_byte_run || high_tick) begin
        high_pcnt <= 8'h00;
      end else if (high_base) begin
        high_pcnt <= 8'(high_pcnt + 8'h01);
      end
    end
  end

  // Active prescale settings follow the register only when stopped or on reload
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_pre_act  <= 4'h0;
      high_pre_act <= 4'h0;
    end else begin
      if (!low_byte_run || low_zero) begin
        low_pre_act <= prescaler_control[BIT_LOW_PRESCALE_EN:POS_LOW_PRESCALE_SEL];
      end
      if (!high_byte_run || high_zero) begin
        high_pre_act <= prescaler_control[BIT_HIGH_PRESCALE_EN:POS_HIGH_PRESCALE_SEL];
      end
    end
  end

  // Byte counters; bus writes never reach them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_byte_count  <= RST_COUNT;
      high_byte_count <= RST_COUNT;
    end else begin
      if (!low_byte_run) begin
        low_byte_count <= 8'h00;
      end else if (low_tick) begin
        low_byte_count <= next_low_count;
      end
      if (!high_byte_run) begin
        high_byte_count <= 8'h00;
      end else if (high_tick) begin
        high_byte_count <= next_high_count;
      end
    end
  end

  // Match buffers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_buf  <= RST_MATCH_DATA;
      high_buf <= RST_MATCH_DATA;
    end else begin
      if (!low_byte_run || low_zero) begin
        low_buf <= low_byte_match_data;
      end
      if (!high_byte_run || high_zero) begin
        high_buf <= high_byte_match_data;
      end
    end
  end

  // Waveform outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_waveform_out_o  <= 1'b1;
      high_waveform_out_o <= 1'b1;
    end else begin
      if (!low_byte_run) begin
        low_waveform_out_o <= 1'b1;
      end else if (low_byte_match_data == MATCH_DATA_FULL) begin
        low_waveform_out_o <= 1'b0;
      end else if (low_pwm) begin
        if (low_match) begin
          low_waveform_out_o <= 1'b1;
        end else if (low_ovf) begin
          low_waveform_out_o <= 1'b0;
        end
      end else if (low_match) begin
        low_waveform_out_o <= !low_waveform_out_o;
      end
      if (!high_byte_run) begin
        high_waveform_out_o <= 1'b1;
      end else if (high_byte_match_data == MATCH_DATA_FULL) begin
        high_waveform_out_o <= 1'b0;
      end else if (high_pwm) begin
        if (high_match) begin
          high_waveform_out_o <= 1'b1;
        end else if (high_ovf) begin
          high_waveform_out_o <= 1'b0;
        end
      end else if (high_match) begin
        high_waveform_out_o <= !high_waveform_out_o;
      end
    end
  end

  // Interrupt request, shared by both bytes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_request_o <= 1'b0;
    end else begin
      irq_request_o <= (timer_control[BIT_HIGH_IRQ_ENABLE] &&
                        timer_control[BIT_HIGH_MATCH_FLAG]) ||
                       (timer_control[BIT_LOW_IRQ_ENABLE] &&
                        timer_control[BIT_LOW_MATCH_FLAG]);
    end
  end

  // AHB-Lite address phase
  assign addr_phase = hsel_i && hready_i &&
                      (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
  assign addr_idx   = word_index(haddr_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_idx  <= 16'h0000;
    end else if (hready_i) begin
      wr_pend <= addr_phase && hwrite_i;
      wr_idx  <= addr_idx;
    end
  end

  // Software registers; hardware flag set wins over a clearing write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_control <= RST_TIMER_CONTROL;
    end else begin
      if (wr_pend && wr_idx == IDX_TIMER_CONTROL) begin
        timer_control <= hwdata_i[7:0];
      end
      if (high_zero) begin
        timer_control[BIT_HIGH_MATCH_FLAG] <= 1'b1;
      end
      if (low_zero) begin
        timer_control[BIT_LOW_MATCH_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prescaler_control    <= RST_PRESCALER_CONTROL;
      low_byte_match_data  <= RST_MATCH_DATA;
      high_byte_match_data <= RST_MATCH_DATA;
    end else if (wr_pend) begin
      if (wr_idx == IDX_PRESCALER_CONTROL) begin
        prescaler_control <= hwdata_i[7:0];
      end else if (wr_idx == IDX_LOW_MATCH_DATA) begin
        low_byte_match_data <= hwdata_i[7:0];
      end else if (wr_idx == IDX_HIGH_MATCH_DATA) begin
        high_byte_match_data <= hwdata_i[7:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    if (addr_idx == IDX_TIMER_CONTROL) begin
      rd_byte = timer_control;
    end else if (addr_idx == IDX_PRESCALER_CONTROL) begin
      rd_byte = prescaler_control;
    end else if (addr_idx == IDX_LOW_BYTE_COUNT) begin
      rd_byte = low_byte_count;
    end else if (addr_idx == IDX_HIGH_BYTE_COUNT) begin
      rd_byte = high_byte_count;
    end else if (addr_idx == IDX_LOW_MATCH_DATA) begin
      rd_byte = low_byte_match_data;
    end else if (addr_idx == IDX_HIGH_MATCH_DATA) begin
      rd_byte = high_byte_match_data;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Zero wait states, always OKAY; read data captured at the address phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= HRESP_OKAY;
      hrdata_o    <= 32'h0000_0000;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= HRESP_OKAY;
      if (addr_phase && !hwrite_i) begin
        hrdata_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_HIGH_STOP_HOLDS: assert property (
    !high_byte_run |=> high_byte_count == 8'h00 && high_buf == $past(high_byte_match_data))
    else $error("stopped high byte not held");
  AST_LOW_STOP_HOLDS: assert property (
    !low_byte_run |=> low_byte_count == 8'h00 && low_buf == $past(low_byte_match_data))
    else $error("stopped low byte not held");
  AST_HIGH_FLAG_SET: assert property (
    high_zero |=> timer_control[BIT_HIGH_MATCH_FLAG])
    else $error("high match flag not set");
  AST_LOW_FLAG_SET: assert property (
    low_zero |=> timer_control[BIT_LOW_MATCH_FLAG])
    else $error("low match flag not set");
  AST_IRQ_HIGH: assert property (
    timer_control[BIT_HIGH_IRQ_ENABLE] && timer_control[BIT_HIGH_MATCH_FLAG] |=> irq_request_o)
    else $error("high interrupt request missing");
  AST_IRQ_LOW: assert property (
    timer_control[BIT_LOW_IRQ_ENABLE] && timer_control[BIT_LOW_MATCH_FLAG] |=> irq_request_o)
    else $error("low interrupt request missing");
  AST_LOW_CLEAR_ON_MATCH: assert property (
    low_match && !output_mode_select && low_byte_run |=> low_byte_count == 8'h00)
    else $error("low counter not cleared on match");
  AST_HIGH_CLEAR_ON_MATCH: assert property (
    high_match && high_clr_on_match && high_byte_run |=> high_byte_count == 8'h00)
    else $error("high counter not cleared on match");
  AST_LOW_BUF_STABLE: assert property (
    low_byte_run && !low_zero |=> low_buf == $past(low_buf))
    else $error("low buffer reloaded off zero");
  AST_LOW_PWM_OVF: assert property (
    low_ovf && !low_match && low_pwm && low_byte_run |=> !low_waveform_out_o)
    else $error("PWM output not low after overflow");
  AST_LOW_STOPPED_HIGH: assert property (
    !low_byte_run ##1 !low_byte_run |-> low_waveform_out_o)
    else $error("stopped output not high");

  COV_LOW_TOGGLE: cover property (low_match && !output_mode_select);
  COV_PWM_OVF: cover property (low_ovf && low_pwm);
  COV_HIGH_FLAG: cover property (high_zero);
  COV_CASCADE: cover property (high_tick && length_select && !output_mode_select);

endmodule
`default_nettype wire

// >>> tb/dbt_pin_monitor.sv
// Pin-side observer that times the high and low phases of one waveform output
`timescale 1ns/1ps
`default_nettype none
module dbt_pin_monitor (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wave_i,
  output logic [15:0]      high_len_o,
  output logic [15:0]      low_len_o
);
  logic        last;
  logic [15:0] run_len;

  // A phase length in clocks is latched when the pin changes level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last       <= 1'b1;
      run_len    <= 16'h0001;
      high_len_o <= 16'h0000;
      low_len_o  <= 16'h0000;
    end else if (wave_i == last) begin
      run_len <= run_len + 16'h0001;
    end else begin
      if (last) begin
        high_len_o <= run_len;
      end else begin
        low_len_o <= run_len;
      end
      run_len <= 16'h0001;
      last    <= wave_i;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the dual byte timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dbt_pkg::*;
  localparam logic [1:0] TR_IDLE = 2'h0;
  logic        clk_i;
  logic        rst_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  logic        wave_lo;
  logic        wave_hi;
  logic [15:0] lo_hi_len;
  logic [15:0] lo_lo_len;
  logic [15:0] hi_hi_len;
  logic [15:0] hi_lo_len;
  int          fail_count = 0;
  int          num_checks = 0;

  dbt_timer dbt_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .irq_request_o(irq), .low_waveform_out_o(wave_lo), .high_waveform_out_o(wave_hi));
  dbt_pin_monitor mon_lo (.clk_i(clk_i), .rst_i(rst_i), .wave_i(wave_lo),
    .high_len_o(lo_hi_len), .low_len_o(lo_lo_len));
  dbt_pin_monitor mon_hi (.clk_i(clk_i), .rst_i(rst_i), .wave_i(wave_hi),
    .high_len_o(hi_hi_len), .low_len_o(hi_lo_len));

  always #5 clk_i = ~clk_i;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t ns: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp(got, exp, what);
  endtask
  task automatic check_pin(input logic got, input logic exp, input string what);
    cmp({31'h0, got}, {31'h0, exp}, what);
  endtask
  task automatic check_len(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp({16'h0, got}, {16'h0, exp}, what);
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) cmp(32'h0, 32'h1, "bus wait expired");
  endtask
  // One single word transfer; read data is taken at the end of the data phase
  task automatic bus_xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                          output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {14'h0000, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready;
    htrans <= TR_IDLE;
    hwdata <= {24'h000000, wd};
    wait_ready;
    rd = hrdata;
  endtask
  task automatic wr_reg(input logic [15:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus_xfer(1'b1, idx, wd, d);
  endtask
  task automatic rd_reg(input logic [15:0] idx, output logic [31:0] rd);
    bus_xfer(1'b0, idx, 8'h00, rd);
  endtask
  // Waits for the chosen pin to enter level lvl, then one more edge for the monitors
  task automatic wait_wave(input logic hi_sel, input logic lvl);
    int n;
    n = 0;
    while ((hi_sel ? wave_hi : wave_lo) === lvl && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    while ((hi_sel ? wave_hi : wave_lo) !== lvl && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) cmp(32'h0, 32'h1, "waveform edge expired");
    @(posedge clk_i);
  endtask
  task automatic settle(input int cycles);
    repeat (cycles) @(posedge clk_i);
  endtask

  task automatic test_reset;
    logic [31:0] d;
    for (logic [15:0] ix = IDX_TIMER_CONTROL; ix <= 16'hFE1E; ix++) begin
      rd_reg(ix, d);
      check_reg(d, 32'h00000000, "reset or unmapped value");
    end
    check_pin(wave_lo, 1'b1, "low pin stopped");
    check_pin(wave_hi, 1'b1, "high pin stopped");
    check_pin(irq, 1'b0, "irq after reset");
    wr_reg(IDX_LOW_BYTE_COUNT, 8'h5A);
    wr_reg(IDX_HIGH_BYTE_COUNT, 8'hA5);
    check_pin(hresp, HRESP_OKAY, "read-only write response");
    wr_reg(IDX_LOW_MATCH_DATA, 8'h3C);
    wr_reg(IDX_HIGH_MATCH_DATA, 8'hC3);
    wr_reg(16'hFE1E, 8'hFF);
    rd_reg(IDX_LOW_BYTE_COUNT, d);
    check_reg(d, 32'h00000000, "low count written");
    rd_reg(IDX_HIGH_BYTE_COUNT, d);
    check_reg(d, 32'h00000000, "high count written");
    rd_reg(IDX_LOW_MATCH_DATA, d);
    check_reg(d, 32'h0000003C, "low match data");
    rd_reg(IDX_HIGH_MATCH_DATA, d);
    check_reg(d, 32'h000000C3, "high match data");
    rd_reg(16'hFE1E, d);
    check_reg(d, 32'h00000000, "unmapped after write");
    $display("test_reset done");
  endtask

  task automatic test_low_pwm;
    logic [31:0] a;
    logic [31:0] b;
    wr_reg(IDX_LOW_MATCH_DATA, 8'h7F);
    wr_reg(IDX_TIMER_CONTROL, 8'h50);
    rd_reg(IDX_LOW_BYTE_COUNT, a);
    rd_reg(IDX_LOW_BYTE_COUNT, b);
    check_reg((b - a) & 32'h000000FF, 32'h00000002, "low count step");
    wait_wave(1'b0, 1'b0);
    wait_wave(1'b0, 1'b1);
    check_len(lo_lo_len, 16'd128, "low pwm low phase");
    wait_wave(1'b0, 1'b0);
    check_len(lo_hi_len, 16'd128, "low pwm high phase");
    rd_reg(IDX_TIMER_CONTROL, a);
    check_reg(a, 32'h00000052, "low flag set");
    wr_reg(IDX_TIMER_CONTROL, 8'h53);
    settle(3);
    check_pin(irq, 1'b1, "low irq raised");
    wr_reg(IDX_TIMER_CONTROL, 8'h01);
    settle(3);
    check_pin(irq, 1'b0, "low irq cleared");
    check_pin(wave_lo, 1'b1, "low pin stopped");
    rd_reg(IDX_LOW_BYTE_COUNT, a);
    check_reg(a, 32'h00000000, "low count stopped");
    wr_reg(IDX_TIMER_CONTROL, 8'h00);
    $display("test_low_pwm done");
  endtask

  task automatic test_defer;
    wr_reg(IDX_LOW_MATCH_DATA, 8'h7F);
    wr_reg(IDX_TIMER_CONTROL, 8'h50);
    wait_wave(1'b0, 1'b0);
    wr_reg(IDX_LOW_MATCH_DATA, 8'h1F);
    wr_reg(IDX_PRESCALER_CONTROL, 8'h08);
    wait_wave(1'b0, 1'b1);
    check_len(lo_lo_len, 16'd128, "old setting low phase");
    wait_wave(1'b0, 1'b0);
    check_len(lo_hi_len, 16'd128, "old setting high phase");
    wait_wave(1'b0, 1'b1);
    check_len(lo_lo_len, 16'd64, "new setting low phase");
    wait_wave(1'b0, 1'b0);
    check_len(lo_hi_len, 16'd448, "new setting high phase");
    wr_reg(IDX_TIMER_CONTROL, 8'h00);
    wr_reg(IDX_PRESCALER_CONTROL, 8'h00);
    $display("test_defer done");
  endtask

  task automatic test_high_pwm;
    logic [31:0] a;
    wr_reg(IDX_HIGH_MATCH_DATA, 8'h1F);
    wr_reg(IDX_PRESCALER_CONTROL, 8'h90);
    wr_reg(IDX_TIMER_CONTROL, 8'h90);
    wait_wave(1'b1, 1'b0);
    wait_wave(1'b1, 1'b1);
    check_len(hi_lo_len, 16'd128, "high pwm low phase");
    wait_wave(1'b1, 1'b0);
    check_len(hi_hi_len, 16'd896, "high pwm high phase");
    check_pin(wave_lo, 1'b1, "low pin while only high runs");
    rd_reg(IDX_TIMER_CONTROL, a);
    check_reg(a, 32'h00000098, "high flag set");
    wr_reg(IDX_TIMER_CONTROL, 8'h9C);
    settle(3);
    check_pin(irq, 1'b1, "high irq raised");
    wr_reg(IDX_TIMER_CONTROL, 8'h04);
    settle(3);
    check_pin(irq, 1'b0, "high irq cleared");
    check_pin(wave_hi, 1'b1, "high pin stopped");
    rd_reg(IDX_HIGH_BYTE_COUNT, a);
    check_reg(a, 32'h00000000, "high count stopped");
    wr_reg(IDX_TIMER_CONTROL, 8'h00);
    wr_reg(IDX_PRESCALER_CONTROL, 8'h00);
    $display("test_high_pwm done");
  endtask

  // Modes 0, 2 and 3 judged by steady half periods on both pins
  task automatic test_modes;
    wr_reg(IDX_LOW_MATCH_DATA, 8'h04);
    wr_reg(IDX_HIGH_MATCH_DATA, 8'h09);
    wr_reg(IDX_TIMER_CONTROL, 8'hC0);
    settle(200);
    check_len(lo_hi_len, 16'd10, "mode0 low toggle");
    check_len(lo_lo_len, 16'd10, "mode0 low toggle");
    check_len(hi_hi_len, 16'd20, "mode0 high toggle");
    wr_reg(IDX_TIMER_CONTROL, 8'h00);
    wr_reg(IDX_LOW_MATCH_DATA, 8'h01);
    wr_reg(IDX_HIGH_MATCH_DATA, 8'h02);
    wr_reg(IDX_TIMER_CONTROL, 8'hE0);
    settle(120);
    check_len(lo_hi_len, 16'd4, "mode2 low toggle");
    check_len(hi_hi_len, 16'd12, "mode2 high toggle");
    check_len(hi_lo_len, 16'd12, "mode2 high toggle");
    wr_reg(IDX_TIMER_CONTROL, 8'h00);
    wr_reg(IDX_LOW_MATCH_DATA, 8'h3F);
    wr_reg(IDX_HIGH_MATCH_DATA, 8'h00);
    wr_reg(IDX_TIMER_CONTROL, 8'hF0);
    settle(1200);
    check_len(lo_lo_len, 16'd64, "mode3 low pwm");
    check_len(lo_hi_len, 16'd192, "mode3 low pwm");
    check_len(hi_hi_len, 16'd256, "mode3 high toggle");
    wr_reg(IDX_TIMER_CONTROL, 8'h00);
    $display("test_modes done");
  endtask

  task automatic test_full_match;
    logic seen_high;
    seen_high = 1'b0;
    wr_reg(IDX_LOW_MATCH_DATA, 8'hFF);
    wr_reg(IDX_TIMER_CONTROL, 8'h50);
    settle(4);
    repeat (600) begin
      @(posedge clk_i);
      if (wave_lo !== 1'b0) seen_high = 1'b1;
    end
    check_pin(seen_high, 1'b0, "low pin held low at full match");
    wr_reg(IDX_TIMER_CONTROL, 8'h00);
    settle(3);
    check_pin(wave_lo, 1'b1, "low pin after stop");
    $display("test_full_match done");
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    cmp(32'h0, 32'h1, "watchdog expired");
    end_of_test;
  end

  initial begin
    clk_i  = 1'b0;
    rst_i  = 1'b1;
    hsel   = 1'b0;
    haddr  = 32'h00000000;
    htrans = TR_IDLE;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h00000000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset;
    test_low_pwm;
    test_defer;
    test_high_pwm;
    test_modes;
    test_full_match;
    end_of_test;
  end
endmodule
`default_nettype wire
